// ### verilog/otsc_top.v
// Output trigger selection, output read-back slot and multi-module sync.
// Assumes all inputs synchronous to clock except the ext trigger and the link trigger and clock.
//
// Behaviour
// R01 - A sample for channel slot 7 carries the current output value.
// R02 - Software trigger starts output when the host writes start.
// R03 - External trigger starts output on a rising edge of its input.
// R04 - Threshold trigger starts output when channel 0 rises above it.
// R05 - Sync mode is master, slave or none, none at reset with local clock.
// R06 - A master drives its trigger and sample clock onto the link.
// R07 - A slave takes trigger and clock from the link, ignoring local ones.
// R08 - The sync mode holds until the host reprograms it.
// R09 - The host arms every slave before starting the master.
// R10 - Master and slaves start within one conversion period of each other.
// R11 - Stopping the master does not stop a slave.
// R12 - Each module programs its own sample rate; a slave ticks on rising edges of the link clock instead of its rateDivider.
// R13 - External and link triggers are synchronised before edge detection.
`timescale 1ns/1ns
`include "otsc_defs.vh"

module otsc_top #(
    parameter DATA_W = 24,
    parameter DIV_W = 16
) (
    input wire clock,
    input wire reset,
    // Host configuration
    input wire [1:0] trigSource,
    input wire [1:0] syncModeIn,
    input wire syncModeWrite,
    input wire [15:0] thresholdMv,
    input wire [DIV_W-1:0] rateDivider,
    input wire outStartCmd,
    input wire outStopCmd,
    input wire inStartCmd,
    input wire inStopCmd,
    // Trigger sources
    input wire extTrigger,
    input wire [2:0] sampleChan,
    input wire [15:0] sampleMv,
    input wire sampleValid,
    input wire [DATA_W-1:0] adcData,
    // Output channel value
    input wire [DATA_W-1:0] outValue,
    // Sync link
    input wire linkTrigIn,
    input wire linkClockIn,
    output reg linkTrigOut_r,
    output reg linkClockOut_r,
    output reg linkDriveEn_r,
    // Status and pacing
    output reg [1:0] syncMode_r,
    output reg outRunning_r,
    output reg inRunning_r,
    output reg sampleTick_r,
    output reg [DATA_W-1:0] streamData_r,
    output reg streamValid_r,
    output reg thresholdBad_r
);

// ----------------------------------------
// Synchronisers and edge detection
// ----------------------------------------
reg extMeta_r;
reg extSync_r;
reg extPrev_r;
reg linkTMeta_r;
reg linkTSync_r;
reg linkTPrev_r;
reg linkCMeta_r;
reg linkCSync_r;
reg linkCPrev_r;

always @(posedge clock) begin
    if (reset) begin
        extMeta_r <= 1'b0;
        extSync_r <= 1'b0;
        extPrev_r <= 1'b0;
        linkTMeta_r <= 1'b0;
        linkTSync_r <= 1'b0;
        linkTPrev_r <= 1'b0;
        linkCMeta_r <= 1'b0;
        linkCSync_r <= 1'b0;
        linkCPrev_r <= 1'b0;
    end else begin
        extMeta_r <= extTrigger; // R13
        extSync_r <= extMeta_r; // R13
        extPrev_r <= extSync_r;
        linkTMeta_r <= linkTrigIn; // R13
        linkTSync_r <= linkTMeta_r; // R13
        linkTPrev_r <= linkTSync_r;
        linkCMeta_r <= linkClockIn;
        linkCSync_r <= linkCMeta_r;
        linkCPrev_r <= linkCSync_r;
    end
end

wire extRise = extSync_r & ~extPrev_r; // R03
wire linkTrigRise = linkTSync_r & ~linkTPrev_r;
wire linkClockRise = linkCSync_r & ~linkCPrev_r;

// ----------------------------------------
// Sync mode
// ----------------------------------------
function isLegalMode;
    input [1:0] m;
    begin
        isLegalMode = (m == `OTSC_SYNC_NONE) || (m == `OTSC_SYNC_MASTER)
            || (m == `OTSC_SYNC_SLAVE);
    end
endfunction

always @(posedge clock) begin
    if (reset) begin
        syncMode_r <= `OTSC_SYNC_NONE; // R05
    end else if (syncModeWrite && isLegalMode(syncModeIn)) begin
        syncMode_r <= syncModeIn; // R05 R08
    end
end

wire isSlave = (syncMode_r == `OTSC_SYNC_SLAVE);
wire isMaster = (syncMode_r == `OTSC_SYNC_MASTER);

// ----------------------------------------
// Threshold trigger
// ----------------------------------------
wire thrLegal = (thresholdMv >= `OTSC_THR_MIN_MV) &&
    (thresholdMv <= `OTSC_THR_MAX_MV);
wire chan0Sample = sampleValid && (sampleChan == `OTSC_THR_CHAN);
reg aboveThr_r;
reg thrCross_r;

always @(posedge clock) begin
    if (reset) begin
        aboveThr_r <= 1'b0;
        thrCross_r <= 1'b0;
        thresholdBad_r <= 1'b0;
    end else begin
        thresholdBad_r <= ~thrLegal; // R04
        thrCross_r <= 1'b0;
        if (chan0Sample) begin
            aboveThr_r <= (sampleMv > thresholdMv);
            thrCross_r <= (sampleMv > thresholdMv) & ~aboveThr_r & thrLegal; // R04
        end
    end
end

// ----------------------------------------
// Local trigger selection
// ----------------------------------------
reg localTrig;
reg outArmed_r;

always @* begin
    case (trigSource)
        `OTSC_TRIG_SW: localTrig = outStartCmd; // R02
        `OTSC_TRIG_EXT: localTrig = outArmed_r & extRise; // R03
        `OTSC_TRIG_THR: localTrig = outArmed_r & thrCross_r; // R04
        default: localTrig = 1'b0;
    endcase
end

// Slave ignores local hardware triggers
wire startEvent = isSlave ? (outArmed_r & linkTrigRise) : localTrig; // R07

// ----------------------------------------
// Output run control
// ----------------------------------------
reg outArmed_nxt;
reg outRunning_nxt;

// Stop wins over start
always @* begin
    outArmed_nxt = outArmed_r;
    outRunning_nxt = outRunning_r;
    if (outStopCmd) begin
        outArmed_nxt = 1'b0;
        outRunning_nxt = 1'b0;
    end else if (startEvent) begin
        outArmed_nxt = 1'b0;
        outRunning_nxt = 1'b1; // R02 R03 R04
    end else if (outStartCmd && !outRunning_r) begin
        outArmed_nxt = 1'b1; // R09
    end
end

always @(posedge clock) begin
    if (reset) begin
        outArmed_r <= 1'b0;
        outRunning_r <= 1'b0;
    end else begin
        outArmed_r <= outArmed_nxt;
        outRunning_r <= outRunning_nxt;
    end
end

// ----------------------------------------
// Input run control
// ----------------------------------------
reg inArmed_r;
reg inArmed_nxt;
reg inRunning_nxt;

// Software source decode
function srcIsSw;
    input [1:0] s;
    begin
        srcIsSw = (s == `OTSC_TRIG_SW);
    end
endfunction

wire inTrig = isSlave ? linkTrigRise : localTrig;
// A slave waits for the link even with software source
wire inSwStart = srcIsSw(trigSource) & ~isSlave; // R07

// Stop wins over start
always @* begin
    inArmed_nxt = inArmed_r;
    inRunning_nxt = inRunning_r;
    if (inStopCmd) begin
        inArmed_nxt = 1'b0;
        inRunning_nxt = 1'b0; // R11
    end else if (inArmed_r && (inTrig || inSwStart)) begin
        inArmed_nxt = 1'b0;
        inRunning_nxt = 1'b1; // R10
    end else if (inStartCmd && !inRunning_r) begin
        inArmed_nxt = 1'b1;
    end
end

always @(posedge clock) begin
    if (reset) begin
        inArmed_r <= 1'b0;
        inRunning_r <= 1'b0;
    end else begin
        inArmed_r <= inArmed_nxt;
        inRunning_r <= inRunning_nxt;
    end
end

// ----------------------------------------
// Sample pacing
// ----------------------------------------
reg [DIV_W-1:0] divCount_r;
wire divDone = (divCount_r == {DIV_W{1'b0}});
// Restart the divider on the start so all modules align
wire restartPace = startEvent | (inArmed_r & inTrig);

always @(posedge clock) begin
    if (reset) begin
        divCount_r <= `OTSC_DIV_DEFAULT;
        sampleTick_r <= 1'b0;
    end else begin
        sampleTick_r <= 1'b0;
        if (restartPace) begin
            divCount_r <= rateDivider; // R10
        end else if (divDone) begin
            divCount_r <= rateDivider; // R12
            sampleTick_r <= ~isSlave & (inRunning_r | outRunning_r); // R05
        end else begin
            divCount_r <= divCount_r - {{(DIV_W-1){1'b0}}, 1'b1};
        end
        if (isSlave && linkClockRise) begin
            sampleTick_r <= inRunning_r | outRunning_r; // R07
        end
    end
end

// ----------------------------------------
// Link drive
// ----------------------------------------
always @(posedge clock) begin
    if (reset) begin
        linkTrigOut_r <= 1'b0;
        linkClockOut_r <= 1'b0;
        linkDriveEn_r <= 1'b0;
    end else begin
        linkDriveEn_r <= isMaster; // R06
        linkTrigOut_r <= isMaster & (outRunning_r | inRunning_r |
            localTrig); // R06
        if (isMaster && divDone) begin
            linkClockOut_r <= ~linkClockOut_r; // R06
        end else if (!isMaster) begin
            linkClockOut_r <= 1'b0;
        end
    end
end

// ----------------------------------------
// Input stream with output read-back
// ----------------------------------------
always @(posedge clock) begin
    if (reset) begin
        streamData_r <= {DATA_W{1'b0}};
        streamValid_r <= 1'b0;
    end else begin
        streamValid_r <= sampleValid & inRunning_r;
        if (sampleValid) begin
            if (sampleChan == `OTSC_READBACK_SLOT) begin
                streamData_r <= outValue; // R01
            end else begin
                streamData_r <= adcData;
            end
        end
    end
end

endmodule

// ### verilog/otsc_defs.vh
// Constants for the output trigger and synchronisation control block.
// Assumes a single 25 MHz clock domain.
`ifndef OTSC_DEFS_VH
`define OTSC_DEFS_VH

// Trigger source codes
`define OTSC_TRIG_SW 2'h0
`define OTSC_TRIG_EXT 2'h1
`define OTSC_TRIG_THR 2'h2

// Synchronisation mode codes
`define OTSC_SYNC_NONE 2'h0
`define OTSC_SYNC_MASTER 2'h1
`define OTSC_SYNC_SLAVE 2'h2

// Channel slot that carries the output read-back
`define OTSC_READBACK_SLOT 3'h7
// Threshold trigger channel
`define OTSC_THR_CHAN 3'h0

// Threshold limits in millivolts
`define OTSC_THR_MIN_MV 16'h00C8
`define OTSC_THR_MAX_MV 16'h2648

// Default sample clock divider
`define OTSC_DIV_DEFAULT 16'h01F4

`endif

// ### tb/otsc_peer_model.sv
// Peer master module on the sync link.
// Assumes the bench raises go once the local module is armed.
`timescale 1ns/1ns
module otsc_peer_model (
    input wire clock,
    input wire go,
    output reg linkTrig_r,
    output reg linkClock_r
);
    reg [1:0] count_r = 2'h0;
    initial begin
        linkTrig_r = 1'h0;
        linkClock_r = 1'h0;
    end
    // Clock stands still while idle
    always @(posedge clock) begin
        linkTrig_r <= go;
        count_r <= go ? count_r + 2'h1 : 2'h0;
        if (go && count_r == 2'h3)
            linkClock_r <= ~linkClock_r;
    end
endmodule

// ### tb/otsc_top_sva.sv
// Port assertions for the trigger and sync block.
// Assumes one clock domain, bound into otsc_top.
`timescale 1ns/1ns
`include "otsc_defs.vh"
module otsc_top_sva #(parameter DATA_W = 24) (
    input wire clock,
    input wire reset,
    input wire [1:0] trigSource,
    input wire [1:0] syncModeIn,
    input wire syncModeWrite,
    input wire [15:0] thresholdMv,
    input wire outStartCmd,
    input wire outStopCmd,
    input wire [2:0] sampleChan,
    input wire sampleValid,
    input wire [DATA_W-1:0] outValue,
    input wire linkDriveEn_r,
    input wire [1:0] syncMode_r,
    input wire outRunning_r,
    input wire [DATA_W-1:0] streamData_r,
    input wire streamValid_r,
    input wire thresholdBad_r
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence swArm;
        outStartCmd && !outStopCmd && trigSource == `OTSC_TRIG_SW
            && syncMode_r == `OTSC_SYNC_NONE;
    endsequence
    sw_start_a: assert property (swArm |=> outRunning_r)
        else $error("software start missed");
    read_back_a: assert property (sampleValid &&
        sampleChan == `OTSC_READBACK_SLOT |=> streamData_r == $past(outValue))
        else $error("read back value wrong");
    valid_cause_a: assert property (streamValid_r |-> $past(sampleValid))
        else $error("stream valid without sample");
    mode_hold_a: assert property (!syncModeWrite |=> $stable(syncMode_r))
        else $error("sync mode changed alone");
    mode_load_a: assert property (syncModeWrite && syncModeIn != 2'h3
        |=> syncMode_r == $past(syncModeIn))
        else $error("sync mode not loaded");
    master_drive_a: assert property ((syncMode_r == 2'h1)[*2]
        |-> linkDriveEn_r)
        else $error("master not driving link");
    link_quiet_a: assert property ((syncMode_r != 2'h1)[*2]
        |-> !linkDriveEn_r)
        else $error("link driven outside master");
    thr_flag_a: assert property ($stable(thresholdMv)[*3] |-> thresholdBad_r
        == (thresholdMv < `OTSC_THR_MIN_MV || thresholdMv > `OTSC_THR_MAX_MV))
        else $error("threshold flag wrong");
endmodule
bind otsc_top otsc_top_sva #(.DATA_W(DATA_W)) chk (.*);

// ### tb/test_output_trigger_sync_control.sv
// Self-checking bench for the trigger and sync block.
// Assumes the checker is bound in and a peer model drives the link.
`timescale 1ns/1ns
`include "otsc_defs.vh"
module test_output_trigger_sync_control;
    reg clock = 0, reset = 1, syncModeWrite = 0, peerGo = 0;
    reg outStartCmd = 0, outStopCmd = 0, inStartCmd = 0, inStopCmd = 0;
    reg extTrigger = 0, sampleValid = 0;
    reg [1:0] trigSource = 0, syncModeIn = 0;
    reg [15:0] thresholdMv = 16'h03E8, sampleMv = 0, rateDivider = 16'h0009;
    reg [2:0] sampleChan = 0;
    reg [23:0] adcData = 0, outValue = 0, expData;
    wire linkTrigIn, linkClockIn, linkTrigOut_r, linkClockOut_r;
    wire linkDriveEn_r, outRunning_r, inRunning_r, sampleTick_r;
    wire streamValid_r, thresholdBad_r;
    wire [1:0] syncMode_r;
    wire [23:0] streamData_r;
    integer seed = 32'hA180, n_fail = 0, compares = 0, i, k, nTick, nTog;
    reg lastClk;
    otsc_top dut (.*);
    otsc_peer_model peer (.clock(clock), .go(peerGo),
        .linkTrig_r(linkTrigIn), .linkClock_r(linkClockIn));
    initial forever #20 clock = ~clock;
    initial #400000 begin
        n_fail = n_fail + 1;
        give_verdict;
    end
    function thrBad(input [15:0] v);
        thrBad = v < `OTSC_THR_MIN_MV || v > `OTSC_THR_MAX_MV;
    endfunction
    task chk(input string what, input [23:0] exp, got);
        compares = compares + 1;
        if (exp !== got) begin
            n_fail = n_fail + 1;
            $display("unexpected %0s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task give_verdict;
        if (n_fail == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task cmd(input [3:0] c);
        @(posedge clock) {outStartCmd, outStopCmd, inStartCmd, inStopCmd} <= c;
        @(posedge clock) {outStartCmd, outStopCmd, inStartCmd, inStopCmd} <= 0;
        #1;
    endtask
    task mode(input [1:0] m);
        @(posedge clock) syncModeIn <= m;
        syncModeWrite <= 1;
        @(posedge clock) syncModeWrite <= 0;
        #3;
    endtask
    task smp(input [2:0] ch, input [15:0] mv);
        @(posedge clock) sampleChan <= ch;
        sampleMv <= mv;
        sampleValid <= 1;
        adcData <= $random(seed);
        outValue <= $random(seed);
        @(posedge clock) sampleValid <= 0;
        expData = ch == `OTSC_READBACK_SLOT ? outValue : adcData;
        #1;
    endtask
    task waitRun;
        repeat (12) if (outRunning_r !== 1) @(posedge clock) #1;
    endtask
    task count40;
        nTick = 0;
        nTog = 0;
        lastClk = linkClockOut_r;
        for (k = 0; k < 40; k = k + 1) begin
            @(posedge clock) #1;
            nTick = nTick + sampleTick_r;
            nTog = nTog + (linkClockOut_r !== lastClk);
            lastClk = linkClockOut_r;
        end
    endtask
    initial begin
        repeat (12) @(posedge clock);
        reset <= 0;
        #1 chk("mode", 0, syncMode_r);
        cmd(4'h8);
        chk("swRun", 1, outRunning_r);
        cmd(4'h4);
        @(posedge clock) trigSource <= `OTSC_TRIG_EXT;
        cmd(4'h8);
        chk("armed", 0, outRunning_r);
        @(posedge clock) extTrigger <= 1;
        waitRun;
        chk("extRun", 1, outRunning_r);
        cmd(4'h4);
        @(posedge clock) trigSource <= `OTSC_TRIG_THR;
        extTrigger <= 0;
        cmd(4'h8);
        smp(`OTSC_THR_CHAN, 16'h0064);
        smp(`OTSC_THR_CHAN, 16'h07D0);
        waitRun;
        chk("thrRun", 1, outRunning_r);
        cmd(4'h4);
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge clock) thresholdMv <= i > 3 ? {$random(seed)} % 12000 :
                (i[1] ? 16'h2648 : 16'h00C7) + i[0];
            repeat (3) @(posedge clock);
            #1 chk("thrBad", thrBad(thresholdMv), thresholdBad_r);
        end
        @(posedge clock) trigSource <= `OTSC_TRIG_SW;
        cmd(4'h2);
        for (i = 0; i < 8; i = i + 1) begin
            smp(i[2:0], 16'h0000);
            chk("data", expData, streamData_r);
            chk("valid", 1, streamValid_r);
        end
        cmd(4'h1);
        mode(`OTSC_SYNC_MASTER);
        @(posedge clock) #1 chk("drive", 1, linkDriveEn_r);
        cmd(4'h2);
        repeat (2) @(posedge clock);
        #1 chk("linkTrig", 1, linkTrigOut_r);
        count40;
        chk("ticks", 40 / (rateDivider + 1), nTick);
        chk("linkClock", 40 / (rateDivider + 1), nTog);
        cmd(4'h1);
        mode(2'h3);
        chk("kept", 1, syncMode_r);
        mode(`OTSC_SYNC_SLAVE);
        @(posedge clock) #1 chk("drive", 0, linkDriveEn_r);
        @(posedge clock) trigSource <= `OTSC_TRIG_EXT;
        cmd(4'hA);
        @(posedge clock) extTrigger <= 1;
        repeat (10) @(posedge clock);
        #1 chk("slaveExt", 0, outRunning_r);
        @(posedge clock) peerGo <= 1;
        waitRun;
        chk("slaveRun", 1, outRunning_r);
        chk("slaveIn", 1, inRunning_r);
        count40;
        chk("slaveTick", 40 / 8, nTick);
        chk("slaveClock", 0, nTog);
        @(posedge clock) peerGo <= 0;
        repeat (10) @(posedge clock);
        #1 chk("slaveKeep", 1, inRunning_r);
        chk("slaveMode", 2, syncMode_r);
        give_verdict;
    end
endmodule
